// file: core/aesrt_params.svh
// Constants of the AES round transform datapath.
`ifndef AESRT_PARAMS_SVH
`define AESRT_PARAMS_SVH
`define AESRT_STATE_W 128
`define AESRT_BYTE_W 8
`define AESRT_REDUCE 8'h1b
`define AESRT_LATENCY 1
`define AESRT_RESET_DATA 128'h0
`endif

// file: core/aesrt_pkg.sv
// Types shared by the AES round transform datapath.
package aesrt_pkg;
    // Operation selector carried with each request.
    typedef enum logic [2:0] {
        AESRT_OP_PASS = 3'h0,
        AESRT_OP_MIX = 3'h1,
        AESRT_OP_SHIFT = 3'h2,
        AESRT_OP_SUB = 3'h3,
        AESRT_OP_ROT = 3'h4,
        AESRT_OP_MUL = 3'h5,
        AESRT_OP_ADD = 3'h6
    } aesrt_op_t;
endpackage : aesrt_pkg

// file: core/aesrt_sbox.sv
// Forward substitution table applied to all sixteen state bytes.
`timescale 1ns/1ps
`include "aesrt_params.svh"
module aesrt_sbox (
    input wire logic [127:0] din, // State to substitute.
    output logic [127:0] dout // Substituted state.
);
    // **********************************************************
    // Table, row 0 first; each row holds sixteen column entries.
    // **********************************************************
    localparam logic [2047:0] TABLE = {
        128'h637c777bf26b6fc53001672bfed7ab76,
        128'hca82c97dfa5947f0add4a2af9ca472c0,
        128'hb7fd9326363ff7cc34a5e5f171d83115,
        128'h04c723c31896059a071280e2eb27b275,
        128'h09832c1a1b6e5aa0523bd6b329e32f84,
        128'h53d100ed20fcb15b6acbbe394a4c58cf,
        128'hd0efaafb434d338545f9027f503c9fa8,
        128'h51a3408f929d38f5bcb6da2110fff3d2,
        128'hcd0c13ec5f974417c4a77e3d645d1973,
        128'h60814fdc222a908846eeb814de5e0bdb,
        128'he0323a0a4906245cc2d3ac629195e479,
        128'he7c8376d8dd54ea96c56f4ea657aae08,
        128'hba78252e1ca6b4c6e8dd741f4bbd8b8a,
        128'h703eb5664803f60e613557b986c11d9e,
        128'he1f8981169d98e949b1e87e9ce5528df,
        128'h8ca1890dbfe6426841992d0fb054bb16
    };

    // **********************************************************
    // Lookup per byte.
    // **********************************************************
    genvar b;
    generate
        for (b = 0; b < 16; b++) begin : g_byte
            logic [7:0] idx;
            // Upper nibble picks the row, lower the column.
            assign idx = din[8*b +: 8];
            assign dout[8*b +: 8] =
                TABLE[2047 - 16*8*idx[7:4] - 8*idx[3:0] -: 8];
        end
    endgenerate
endmodule : aesrt_sbox

// file: core/aesrt_top.sv
// AES round transform datapath with one registered result stage.
`timescale 1ns/1ps
`include "aesrt_params.svh"
module aesrt_top
    import aesrt_pkg::*;
(
    input wire logic CLK, // 200 MHz clock.
    input wire logic ARST_N, // Asynchronous reset, active low.
    input wire logic OP_VALID, // Request strobe.
    input wire aesrt_op_t OP_CODE, // Transform to apply.
    input wire logic [127:0] OP_STATE, // State operand.
    input wire logic [127:0] OP_KEY, // Round key operand.
    output logic RES_VALID, // Result valid pulse.
    output logic [127:0] RES_DATA // Registered result.
);
    // **********************************************************
    // Field arithmetic.
    // **********************************************************

    // Carry-less multiply with reduction folded into each shift.
    function automatic logic [7:0] field_byte_multiply(
        input logic [7:0] a,
        input logic [7:0] m
    );
        logic [7:0] p;
        logic [7:0] t;
        p = 8'h00;
        t = a;
        for (int k = 0; k < 8; k++) begin
            if (m[k]) begin
                p = p ^ t;
            end
            t = {t[6:0], 1'b0} ^ (t[7] ? `AESRT_REDUCE : 8'h00);
        end
        return p;
    endfunction : field_byte_multiply

    // **********************************************************
    // Transforms, each on the column-major byte matrix.
    // **********************************************************
    logic [127:0] mix_out;
    logic [127:0] shift_out;
    logic [127:0] sub_out;
    logic [127:0] rot_out;
    logic [127:0] mul_out;

    genvar j, i;
    generate
        for (j = 0; j < 4; j++) begin : g_col
            // Word j holds rows 3..0 of column j, row 0 lowest.
            assign rot_out[32*j +: 32] =
                {OP_STATE[32*j +: 8], OP_STATE[32*j+8 +: 24]};
            for (i = 0; i < 4; i++) begin : g_row
                localparam int B = 4*j + i;
                localparam int R1 = 4*j + (i+1)%4;
                localparam int R2 = 4*j + (i+2)%4;
                localparam int R3 = 4*j + (i+3)%4;
                localparam int SRC = 4*((j+i)%4) + i;
                // Column mixing with the fixed 2,3,1,1 row.
                assign mix_out[8*B +: 8] =
                    field_byte_multiply(8'h02, OP_STATE[8*B +: 8]) ^
                    field_byte_multiply(8'h03, OP_STATE[8*R1 +: 8]) ^
                    OP_STATE[8*R2 +: 8] ^ OP_STATE[8*R3 +: 8];
                // Row i takes the byte i columns further right.
                assign shift_out[8*B +: 8] = OP_STATE[8*SRC +: 8];
                // Bytewise field product of state and key.
                assign mul_out[8*B +: 8] = field_byte_multiply(
                    OP_STATE[8*B +: 8], OP_KEY[8*B +: 8]);
            end
        end
    endgenerate

    // Substitution of every byte through the table.
    aesrt_sbox u_sbox (
        .din(OP_STATE),
        .dout(sub_out)
    );

    // **********************************************************
    // Result stage.
    // **********************************************************
    logic next_res_valid;
    logic [127:0] next_res_data;

    // Select the transform; data holds while no request comes.
    always_comb begin
        next_res_valid = OP_VALID;
        next_res_data = RES_DATA;
        if (OP_VALID) begin
            case (OP_CODE)
                AESRT_OP_MIX: begin
                    next_res_data = mix_out;
                end
                AESRT_OP_SHIFT: begin
                    next_res_data = shift_out;
                end
                AESRT_OP_SUB: begin
                    next_res_data = sub_out;
                end
                AESRT_OP_ROT: begin
                    next_res_data = rot_out;
                end
                AESRT_OP_MUL: begin
                    next_res_data = mul_out;
                end
                AESRT_OP_ADD: begin
                    next_res_data = OP_STATE ^ OP_KEY;
                end
                default: begin
                    next_res_data = OP_STATE;
                end
            endcase
        end
    end

    // Register the result so outputs come from flip-flops.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RES_VALID <= 1'b0;
            RES_DATA <= `AESRT_RESET_DATA;
        end else begin
            RES_VALID <= next_res_valid;
            RES_DATA <= next_res_data;
        end
    end

    // **********************************************************
    // Checks.
    // **********************************************************

    // A request yields a valid one clock later.
    chk_valid_latency: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        OP_VALID |-> ##`AESRT_LATENCY RES_VALID)
        else $error("Result valid missing after request.");

    // Valid never appears without a request before it.
    chk_valid_cause: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        RES_VALID |-> $past(OP_VALID))
        else $error("Result valid without request.");

    // Idle cycles keep the result steady.
    chk_result_hold: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        !OP_VALID |=> $stable(RES_DATA))
        else $error("Result changed without request.");

    // Known substitution entries for zero and one.
    chk_sub_known: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        OP_VALID && OP_CODE == AESRT_OP_SUB && OP_STATE[15:0] == 16'h0100
        |=> RES_DATA[15:0] == 16'h7c63)
        else $error("Substitution table entry wrong.");

    // Upper nibble picks the row: 10 lands in row one, ff in the last.
    chk_sub_rows: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        OP_VALID && OP_CODE == AESRT_OP_SUB &&
        OP_STATE[39:24] == 16'hff10
        |=> RES_DATA[39:24] == 16'h16ca)
        else $error("Substitution row or column wrong.");

    // Row one of column zero comes from column one.
    chk_shift_rows: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        OP_VALID && OP_CODE == AESRT_OP_SHIFT
        |=> RES_DATA[15:8] == $past(OP_STATE[47:40]) &&
            RES_DATA[31:24] == $past(OP_STATE[127:120]) &&
            RES_DATA[7:0] == $past(OP_STATE[7:0]))
        else $error("Row shift moved a byte wrongly.");

    // Row two of column zero comes from column two; row three of column one wraps around to column zero.
    chk_shift_wrap: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        OP_VALID && OP_CODE == AESRT_OP_SHIFT
        |=> RES_DATA[23:16] == $past(OP_STATE[87:80]) &&
            RES_DATA[63:56] == $past(OP_STATE[31:24]))
        else $error("Row shift wrap-around wrong.");

    // Word zero rotates one byte right.
    chk_rot_word: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        OP_VALID && OP_CODE == AESRT_OP_ROT
        |=> RES_DATA[31:0] ==
            {$past(OP_STATE[7:0]), $past(OP_STATE[31:8])})
        else $error("Word rotation wrong.");

    // The high word rotates the same way as word zero.
    chk_rot_high: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        OP_VALID && OP_CODE == AESRT_OP_ROT
        |=> RES_DATA[127:96] ==
            {$past(OP_STATE[103:96]), $past(OP_STATE[127:104])})
        else $error("High word rotation wrong.");

    // Known column mixing vector on column zero.
    chk_mix_vector: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        OP_VALID && OP_CODE == AESRT_OP_MIX &&
        OP_STATE[31:0] == 32'h455313db
        |=> RES_DATA[31:0] == 32'hbca14d8e)
        else $error("Column mixing result wrong.");

    // Known column mixing vector on column one.
    chk_mix_second: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        OP_VALID && OP_CODE == AESRT_OP_MIX &&
        OP_STATE[63:32] == 32'h305dbfd4
        |=> RES_DATA[63:32] == 32'he5816604)
        else $error("Column mixing on column one wrong.");

    // Known field product 57 times 83 gives c1.
    chk_field_mul: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        OP_VALID && OP_CODE == AESRT_OP_MUL &&
        OP_STATE[7:0] == 8'h57 && OP_KEY[7:0] == 8'h83
        |=> RES_DATA[7:0] == 8'hc1)
        else $error("Field multiply result wrong.");

    // A product past the top bit folds back through the reduction.
    chk_mul_reduce: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        OP_VALID && OP_CODE == AESRT_OP_MUL &&
        OP_STATE[15:8] == 8'h80 && OP_KEY[15:8] == 8'h02
        |=> RES_DATA[15:8] == 8'h1b)
        else $error("Field multiply reduction wrong.");

    // Key addition is a plain XOR of both operands.
    chk_key_add: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        OP_VALID && OP_CODE == AESRT_OP_ADD
        |=> RES_DATA == ($past(OP_STATE) ^ $past(OP_KEY)))
        else $error("Field addition wrong.");

    // Pass-through keeps byte order untouched.
    chk_pass_order: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        OP_VALID && OP_CODE == AESRT_OP_PASS
        |=> RES_DATA == $past(OP_STATE))
        else $error("Pass-through reordered bytes.");
endmodule : aesrt_top

// file: tb/aesrt_pipe_model.sv
// Execution pipeline stand-in that takes back datapath results.
`timescale 1ns/1ps
module aesrt_pipe_model (
    input wire logic clk, // Clock.
    input wire logic arst_n, // Reset, active low.
    input wire logic res_valid, // Result pulse from the datapath.
    input wire logic [127:0] res_data, // Result from the datapath.
    output logic [127:0] wb_data, // Last result written back.
    output int wb_count // Number of results written back.
);
    // Write back a result only in a cycle that carries the valid pulse.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_data <= 128'h0;
            wb_count <= 0;
        end else if (res_valid) begin
            wb_data <= res_data;
            wb_count <= wb_count + 1;
        end
    end
endmodule : aesrt_pipe_model

// file: tb/tb_aes_round_transforms.sv
// Self-checking testbench of the AES round transform datapath.
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
    n_errors++; $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); \
    end end
module tb_aes_round_transforms;
    import aesrt_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic op_valid = 1'b0;
    aesrt_op_t op_code = AESRT_OP_PASS;
    logic [127:0] op_state = 128'h0;
    logic [127:0] op_key = 128'h0;
    logic res_valid;
    logic [127:0] res_data;
    logic [127:0] wb_data;
    logic [127:0] last_exp = 128'h0;
    int wb_count;
    int n_errors = 0;
    int samples_checked = 0;
    int n_ops = 0;
    int cycles = 0;
    localparam logic [127:0] RAMP = 128'h0f0e0d0c_0b0a0908_07060504_03020100;

    aesrt_top uut (.CLK(clk), .ARST_N(arst_n), .OP_VALID(op_valid),
        .OP_CODE(op_code), .OP_STATE(op_state), .OP_KEY(op_key),
        .RES_VALID(res_valid), .RES_DATA(res_data));
    aesrt_pipe_model pipe (.clk(clk), .arst_n(arst_n), .res_valid(res_valid),
        .res_data(res_data), .wb_data(wb_data), .wb_count(wb_count));

    // Clock of 5 ns period and a cycle ceiling that cuts a hang short.
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            print_verdict();
        end
    end

    // Present one request, then judge the pulse and the held result.
    task automatic do_op(input aesrt_op_t op, input logic [127:0] s, k, e);
        @(negedge clk);
        op_valid = 1'b1;
        op_code = op;
        op_state = s;
        op_key = k;
        @(negedge clk);
        op_valid = 1'b0;
        `CHK(res_valid, 1'b1)
        `CHK(res_data, e)
        @(negedge clk);
        `CHK(res_valid, 1'b0)
        `CHK(res_data, e)
        n_ops++;
        last_exp = e;
    endtask : do_op

    task automatic t_sub;
        do_op(AESRT_OP_SUB, {88'h0, 40'hff10530100}, 128'h0,
            {{11{8'h63}}, 40'h16caed7c63});
    endtask : t_sub

    task automatic t_mix;
        do_op(AESRT_OP_MIX, {32'h0, 32'h01010101, 32'h305dbfd4, 32'h455313db},
            128'h0, {32'h0, 32'h01010101, 32'he5816604,
            32'hbca14d8e});
    endtask : t_mix

    task automatic t_shift;
        logic [127:0] e;
        for (int j = 0; j < 4; j++) begin
            for (int i = 0; i < 4; i++) begin
                e[8*(4*j+i)+:8] = 8'(4*((j+i)%4)+i);
            end
        end
        do_op(AESRT_OP_SHIFT, RAMP, 128'h0, e);
    endtask : t_shift

    task automatic t_rot;
        do_op(AESRT_OP_ROT, RAMP, 128'h0,
            128'h0c0f0e0d_080b0a09_04070605_00030201);
    endtask : t_rot

    task automatic t_mul;
        do_op(AESRT_OP_MUL, {104'h0, 24'h018057}, {{13{8'h5a}}, 24'hab0283},
            {104'h0, 24'hab1bc1});
    endtask : t_mul

    task automatic t_add_pass;
        do_op(AESRT_OP_ADD, RAMP, {16{8'hff}}, ~RAMP);
        do_op(AESRT_OP_PASS, RAMP, {16{8'hff}}, RAMP);
        do_op(aesrt_op_t'(3'h7), ~RAMP, RAMP, ~RAMP);
    endtask : t_add_pass

    // Reset in mid-run clears the result at once and restarts the count.
    task automatic t_reset;
        @(negedge clk);
        arst_n = 1'b0;
        #1;
        `CHK(res_valid, 1'b0)
        `CHK(res_data, 128'h0)
        `CHK(wb_count, 0)
        @(negedge clk);
        arst_n = 1'b1;
        n_ops = 0;
        last_exp = 128'h0;
    endtask : t_reset

    // Two requests on consecutive edges keep the pulse high for both.
    task automatic t_b2b;
        @(negedge clk);
        op_valid = 1'b1;
        op_code = AESRT_OP_ADD;
        op_state = RAMP;
        op_key = 128'h1;
        @(negedge clk);
        op_code = AESRT_OP_PASS;
        op_state = 128'h5;
        `CHK(res_valid, 1'b1)
        `CHK(res_data, RAMP ^ 128'h1)
        @(negedge clk);
        op_valid = 1'b0;
        `CHK(res_valid, 1'b1)
        `CHK(res_data, 128'h5)
        @(negedge clk);
        `CHK(res_valid, 1'b0)
        n_ops += 2;
        last_exp = 128'h5;
    endtask : t_b2b

    // Report the counts and the verdict, then end the run.
    task automatic print_verdict;
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    // Main sequence: reset, every transform, then the write-back count.
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        `CHK(res_valid, 1'b0)
        `CHK(res_data, 128'h0)
        t_sub();
        t_mix();
        t_shift();
        t_rot();
        t_mul();
        t_add_pass();
        t_reset();
        t_b2b();
        @(negedge clk);
        `CHK(wb_count, n_ops)
        `CHK(wb_data, last_exp)
        print_verdict();
    end
endmodule : tb_aes_round_transforms
